// ---- core/exposure_timing_pkg.sv ----
// Purpose: Shared constants and carriers for the exposure and frame timing block
// Assumes: Byte-wide register port with a one-bit page select
// Notes:   Offsets are byte addresses within their page

package exposure_timing_pkg;

    // Pages
    localparam logic       PAGE_SYSTEM          = 1'h0;
    localparam logic       PAGE_SENSOR          = 1'h1;

    // Offsets
    localparam logic [7:0] OFF_CLOCK_DIVIDER    = 8'h31;
    localparam logic [7:0] OFF_CLOCK_SOURCE     = 8'h32;
    localparam logic [7:0] OFF_UPDATE_HOLD      = 8'h01;
    localparam logic [7:0] OFF_EXPOSURE_HIGH    = 8'h03;
    localparam logic [7:0] OFF_EXPOSURE_LOW     = 8'h04;
    localparam logic [7:0] OFF_VBLANK_HIGH      = 8'h05;
    localparam logic [7:0] OFF_VBLANK_LOW       = 8'h06;
    localparam logic [7:0] OFF_SYNC_TO_LINE     = 8'h08;
    localparam logic [7:0] OFF_HBLANK_HIGH      = 8'h09;
    localparam logic [7:0] OFF_HBLANK_LOW       = 8'h0A;
    localparam logic [7:0] OFF_LONG_DELAY_HIGH  = 8'h41;
    localparam logic [7:0] OFF_LONG_DELAY_LOW   = 8'h42;
    localparam logic [7:0] OFF_FRAME_LEN_HIGH   = 8'h4E;
    localparam logic [7:0] OFF_FRAME_LEN_LOW    = 8'h4F;
    localparam logic [7:0] OFF_LINE_TOTAL_HIGH  = 8'hDA;
    localparam logic [7:0] OFF_LINE_TOTAL_LOW   = 8'hDB;

    // Reset values
    localparam logic [7:0]  RST_CLOCK_DIVIDER   = 8'h90;
    localparam logic [7:0]  RST_CLOCK_SOURCE    = 8'h04;
    localparam logic [15:0] RST_EXPOSURE        = 16'h019A;
    localparam logic [15:0] RST_VBLANK          = 16'h0000;
    localparam logic [3:0]  RST_SYNC_TO_LINE    = 4'h1;
    localparam logic [11:0] RST_HBLANK          = 12'h000;
    localparam logic [15:0] RST_LONG_DELAY      = 16'h0000;
    localparam logic        RST_HOLD_ENABLE     = 1'h0;

    // Field positions
    localparam int PLL_HALF_BIT    = 7;
    localparam int ROW_DIV_LSB     = 4;
    localparam int TIMER_DIV_LSB   = 0;
    localparam int ROW_SOURCE_BIT  = 4;
    localparam int DATA_DIV_LSB    = 0;
    localparam int HOLD_ENABLE_BIT = 0;

    typedef struct packed {
        logic       page;
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] exposure;
        logic [15:0] vblank;
        logic [11:0] hblank;
        logic [15:0] long_delay;
    } timing_set_t;

    typedef struct packed {
        logic vsync;
        logic hsync;
        logic line_valid;
        logic row_tick;
        logic timer_tick;
        logic data_tick;
        logic frame_start;
    } sync_out_t;

endpackage

// ---- core/exposure_frame_timing.sv ----
// Purpose: Exposure, blanking and frame timing with clock-mode dividers
// Assumes: clk_i is the incoming pixel clock; all inputs synchronous to it
// Notes:   Derived clocks are one-cycle tick strobes, not real clocks
`timescale 1ns/100ps
`default_nettype none

module exposure_frame_timing #(
    parameter logic [15:0] ACTIVE_ROWS  = 16'h0010,
    parameter logic [15:0] ACTIVE_WIDTH = 16'h0040
) (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              srst_i,
    // Register port
    input  wire exposure_timing_pkg::reg_req_t     reg_req_i,
    output logic [7:0]                             reg_rdata_o,
    // Mode and external row clock
    input  wire logic                              binning_mode_i,
    input  wire logic                              ext_clk_i,
    // Timing outputs
    output exposure_timing_pkg::sync_out_t         sync_o,
    output exposure_timing_pkg::timing_set_t       active_o
);

    typedef struct packed {
        logic [7:0]                       clk_div;
        logic [7:0]                       clk_src;
        exposure_timing_pkg::timing_set_t buffered;
        exposure_timing_pkg::timing_set_t active;
        logic [3:0]                       sync_rows;
        logic                             hold_en;
        logic                             pending;
        logic                             pll_phase;
        logic [2:0]                       timer_cnt;
        logic [2:0]                       row_cnt;
        logic [1:0]                       data_cnt;
        logic                             ext_q;
        logic [15:0]                      col;
        logic [15:0]                      row;
        logic [15:0]                      frame_ro;
        logic [7:0]                       rdata;
        exposure_timing_pkg::sync_out_t   sync;
    } state_t;

    state_t st;
    state_t next_st;

    // Undefined codes fall back to divide by one rather than stalling
    function automatic logic [2:0] div_mask(input logic [2:0] code);
        case (code)
            3'h0:    div_mask = 3'h0;
            3'h1:    div_mask = 3'h1;
            3'h2:    div_mask = 3'h3;
            3'h4:    div_mask = 3'h7;
            default: div_mask = 3'h0;
        endcase
    endfunction

    function automatic logic hit(input logic page, input logic [7:0] off);
        hit = (reg_req_i.page == page) && (reg_req_i.addr == off);
    endfunction

    logic [2:0]  timer_mask;
    logic [2:0]  row_mask;
    logic [2:0]  data_mask;
    logic        pll_en;
    logic        timer_en;
    logic        src_en;
    logic        row_en;
    logic        data_en;
    logic [15:0] line_total;
    logic [15:0] frame_base;
    logic [15:0] frame_len;
    logic        row_end;
    logic        frame_end;
    logic        commit;
    logic        hold_write;

    always_comb
    begin
        timer_mask = div_mask(st.clk_div[exposure_timing_pkg::TIMER_DIV_LSB +: 3]);
        row_mask   = div_mask(st.clk_div[exposure_timing_pkg::ROW_DIV_LSB +: 3]);
        data_mask  = div_mask({1'b0, st.clk_src[exposure_timing_pkg::DATA_DIV_LSB +: 2]});
        // Bypass or every other input cycle
        pll_en     = !st.clk_div[exposure_timing_pkg::PLL_HALF_BIT] || st.pll_phase;
        timer_en   = pll_en && ((st.timer_cnt & timer_mask) == timer_mask);
        src_en     = st.clk_src[exposure_timing_pkg::ROW_SOURCE_BIT]
                     ? (ext_clk_i && !st.ext_q) : timer_en;
        row_en     = src_en && ((st.row_cnt & row_mask) == row_mask);
        data_en    = timer_en && ((st.data_cnt[1:0] & data_mask[1:0]) == data_mask[1:0]);
        // Line total includes the blanking; row period counts row clock ticks
        line_total = ACTIVE_WIDTH + {4'h0, st.active.hblank};
        frame_base = ACTIVE_ROWS + {12'h000, st.sync_rows} + st.active.vblank;
        // Sums wrap at sixteen bits; software keeps totals in range
        frame_len  = (st.active.exposure > frame_base)
                     ? frame_base + st.active.long_delay : frame_base;
        row_end    = row_en && (st.col >= line_total - 16'h0001);
        frame_end  = row_end && (st.row >= frame_len - 16'h0001);
        commit     = frame_end && (!st.hold_en || st.pending);
        hold_write = reg_req_i.wr && hit(exposure_timing_pkg::PAGE_SENSOR,
                                         exposure_timing_pkg::OFF_UPDATE_HOLD);
    end

    always_comb
    begin
        next_st = st;
        // Clock-mode dividers
        next_st.pll_phase = !st.pll_phase;
        if (pll_en)
        begin
            next_st.timer_cnt = st.timer_cnt + 3'h1;
        end
        if (src_en)
        begin
            next_st.row_cnt = st.row_cnt + 3'h1;
        end
        if (timer_en)
        begin
            next_st.data_cnt = st.data_cnt + 2'h1;
        end
        next_st.ext_q = ext_clk_i;
        // Register writes
        if (reg_req_i.wr)
        begin
            if (hit(exposure_timing_pkg::PAGE_SYSTEM, exposure_timing_pkg::OFF_CLOCK_DIVIDER))
                next_st.clk_div = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SYSTEM, exposure_timing_pkg::OFF_CLOCK_SOURCE))
                next_st.clk_src = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_EXPOSURE_HIGH))
                next_st.buffered.exposure[15:8] = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_EXPOSURE_LOW))
                next_st.buffered.exposure[7:0] = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_VBLANK_HIGH))
                next_st.buffered.vblank[15:8] = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_VBLANK_LOW))
                next_st.buffered.vblank[7:0] = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_SYNC_TO_LINE))
                next_st.sync_rows = reg_req_i.wdata[3:0];
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_HBLANK_HIGH))
                next_st.buffered.hblank[11:8] = reg_req_i.wdata[3:0];
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_HBLANK_LOW))
                next_st.buffered.hblank[7:0] = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_LONG_DELAY_HIGH))
                next_st.buffered.long_delay[15:8] = reg_req_i.wdata;
            if (hit(exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_LONG_DELAY_LOW))
                next_st.buffered.long_delay[7:0] = reg_req_i.wdata;
            if (hold_write)
                next_st.hold_en = reg_req_i.wdata[exposure_timing_pkg::HOLD_ENABLE_BIT];
        end
        // A request landing in the commit cycle is kept for the next frame
        next_st.pending = (st.pending && !commit)
                          || (hold_write
                              && reg_req_i.wdata[exposure_timing_pkg::HOLD_ENABLE_BIT]);
        if (commit)
        begin
            next_st.active = st.buffered;
            // Zero exposure is illegal; one row is the floor
            if (st.buffered.exposure == 16'h0000)
                next_st.active.exposure = 16'h0001;
        end
        // Row and frame counters
        if (row_en)
        begin
            next_st.col = row_end ? 16'h0000 : st.col + 16'h0001;
        end
        if (row_end)
        begin
            next_st.row = frame_end ? 16'h0000 : st.row + 16'h0001;
        end
        if (frame_end)
        begin
            next_st.frame_ro = binning_mode_i ? {1'b0, frame_len[15:1]} : frame_len;
        end
        // Sync outputs
        next_st.sync.frame_start = frame_end;
        next_st.sync.vsync       = (next_st.row < {12'h000, st.sync_rows});
        next_st.sync.line_valid  = (next_st.row >= {12'h000, st.sync_rows})
                                   && (next_st.row < {12'h000, st.sync_rows} + ACTIVE_ROWS);
        next_st.sync.hsync       = next_st.sync.line_valid && (next_st.col < ACTIVE_WIDTH);
        next_st.sync.timer_tick  = timer_en;
        next_st.sync.row_tick    = row_en;
        next_st.sync.data_tick   = data_en;
        // Read data, one cycle after the request
        next_st.rdata = 8'h00;
        if (reg_req_i.rd)
        begin
            case ({reg_req_i.page, reg_req_i.addr})
                {exposure_timing_pkg::PAGE_SYSTEM, exposure_timing_pkg::OFF_CLOCK_DIVIDER}:
                    next_st.rdata = st.clk_div;
                {exposure_timing_pkg::PAGE_SYSTEM, exposure_timing_pkg::OFF_CLOCK_SOURCE}:
                    next_st.rdata = st.clk_src;
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_UPDATE_HOLD}:
                    next_st.rdata = {7'h00, st.hold_en};
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_EXPOSURE_HIGH}:
                    next_st.rdata = st.buffered.exposure[15:8];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_EXPOSURE_LOW}:
                    next_st.rdata = st.buffered.exposure[7:0];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_VBLANK_HIGH}:
                    next_st.rdata = st.buffered.vblank[15:8];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_VBLANK_LOW}:
                    next_st.rdata = st.buffered.vblank[7:0];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_SYNC_TO_LINE}:
                    next_st.rdata = {4'h0, st.sync_rows};
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_HBLANK_HIGH}:
                    next_st.rdata = {4'h0, st.buffered.hblank[11:8]};
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_HBLANK_LOW}:
                    next_st.rdata = st.buffered.hblank[7:0];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_LONG_DELAY_HIGH}:
                    next_st.rdata = st.buffered.long_delay[15:8];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_LONG_DELAY_LOW}:
                    next_st.rdata = st.buffered.long_delay[7:0];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_FRAME_LEN_HIGH}:
                    next_st.rdata = st.frame_ro[15:8];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_FRAME_LEN_LOW}:
                    next_st.rdata = st.frame_ro[7:0];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_LINE_TOTAL_HIGH}:
                    next_st.rdata = line_total[15:8];
                {exposure_timing_pkg::PAGE_SENSOR, exposure_timing_pkg::OFF_LINE_TOTAL_LOW}:
                    next_st.rdata = line_total[7:0];
                default:
                    next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st                   <= '0;
            st.clk_div           <= exposure_timing_pkg::RST_CLOCK_DIVIDER;
            st.clk_src           <= exposure_timing_pkg::RST_CLOCK_SOURCE;
            st.buffered.exposure <= exposure_timing_pkg::RST_EXPOSURE;
            st.buffered.vblank   <= exposure_timing_pkg::RST_VBLANK;
            st.buffered.hblank   <= exposure_timing_pkg::RST_HBLANK;
            st.buffered.long_delay <= exposure_timing_pkg::RST_LONG_DELAY;
            st.active.exposure   <= exposure_timing_pkg::RST_EXPOSURE;
            st.active.vblank     <= exposure_timing_pkg::RST_VBLANK;
            st.active.hblank     <= exposure_timing_pkg::RST_HBLANK;
            st.active.long_delay <= exposure_timing_pkg::RST_LONG_DELAY;
            st.sync_rows         <= exposure_timing_pkg::RST_SYNC_TO_LINE;
            st.hold_en           <= exposure_timing_pkg::RST_HOLD_ENABLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign sync_o      = st.sync;
    assign active_o    = st.active;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence seq_boundary;
        frame_end;
    endsequence

    sequence seq_held_boundary;
        frame_end && st.hold_en && !st.pending;
    endsequence

    chk_commit_copies: assert property (seq_boundary ##0 commit |=>
        st.active.hblank == $past(st.buffered.hblank))
        else $error("commit did not copy horizontal blank");
    chk_hold_blocks: assert property (seq_held_boundary |=>
        $stable(st.active))
        else $error("held settings changed without update request");
    chk_pending_set: assert property (hold_write && reg_req_i.wdata[0] |=> st.pending)
        else $error("update request was lost");
    chk_exposure_floor: assert property (st.active.exposure != 16'h0000)
        else $error("active exposure is zero");
    chk_line_total: assert property (reg_req_i.rd && reg_req_i.page
        && reg_req_i.addr == exposure_timing_pkg::OFF_LINE_TOTAL_LOW
        |=> reg_rdata_o == $past(line_total[7:0]))
        else $error("line total read back wrong");
    chk_frame_full: assert property (seq_boundary ##0 !binning_mode_i
        |=> st.frame_ro == $past(frame_len))
        else $error("full-size frame length wrong");
    chk_frame_binned: assert property (seq_boundary ##0 binning_mode_i
        |=> st.frame_ro == ($past(frame_len) >> 1))
        else $error("binned frame length not halved");
    chk_pll_half: assert property (st.clk_div[7] && pll_en ##1 st.clk_div[7] |-> !pll_en)
        else $error("halved pll clock ran two cycles");
    chk_timer_div: assert property (timer_en && timer_mask != 3'h0
        ##1 st.clk_div == $past(st.clk_div) |-> !timer_en)
        else $error("divided timer clock ticked back to back");
    chk_long_delay: assert property (st.active.exposure > frame_base
        |-> frame_len == frame_base + st.active.long_delay)
        else $error("long exposure delay not added");
    chk_hsync_after: assert property (sync_o.hsync
        |-> st.row >= {12'h000, $past(st.sync_rows)})
        else $error("line sync before frame sync offset");
    chk_row_div: assert property (row_en && row_mask != 3'h0
        ##1 st.clk_div == $past(st.clk_div) |-> !row_en)
        else $error("divided row clock ticked back to back");
    chk_data_div: assert property (data_en && data_mask != 3'h0
        ##1 st.clk_src == $past(st.clk_src) |-> !data_en)
        else $error("divided data clock ticked back to back");
    // One row tick per external rising edge, not per high cycle
    chk_ext_edge: assert property (ext_clk_i
        ##1 st.clk_src[exposure_timing_pkg::ROW_SOURCE_BIT] |-> !src_en)
        else $error("external row source ticked twice");
    chk_col_wrap: assert property (row_end |=> st.col == 16'h0000)
        else $error("column count did not wrap at line end");
    chk_sync_apart: assert property (!(sync_o.vsync && sync_o.line_valid))
        else $error("frame sync overlaps active lines");
    chk_rdata_idle: assert property (!reg_req_i.rd |=> reg_rdata_o == 8'h00)
        else $error("read data stood without a read");
    chk_pending_clear: assert property (commit && !hold_write |=> !st.pending)
        else $error("update request survived its commit");
    chk_frame_len_high: assert property (reg_req_i.rd && reg_req_i.page
        && reg_req_i.addr == exposure_timing_pkg::OFF_FRAME_LEN_HIGH
        |=> reg_rdata_o == $past(st.frame_ro[15:8]))
        else $error("frame length high byte read back wrong");

endmodule

`default_nettype wire

// ---- dv/tb_exposure_frame_timing.sv ----
// Purpose: Self-checking bench for exposure_frame_timing
// Assumes: Short geometry parameters keep frames to a few hundred cycles
// Notes:   Inputs change at the falling edge, outputs are sampled there too
`timescale 1ns/100ps
`default_nettype none

module tb_exposure_frame_timing;
    localparam logic [15:0] ROWS  = 16'h0004;
    localparam logic [15:0] WIDTH = 16'h0008;
    // Page, offset and reset value of every writable register
    localparam logic [16:0] RST_TAB [12] = '{
        {1'h0, 8'h31, 8'h90}, {1'h0, 8'h32, 8'h04}, {1'h1, 8'h01, 8'h00},
        {1'h1, 8'h03, 8'h01}, {1'h1, 8'h04, 8'h9A}, {1'h1, 8'h05, 8'h00},
        {1'h1, 8'h06, 8'h00}, {1'h1, 8'h08, 8'h01}, {1'h1, 8'h09, 8'h00},
        {1'h1, 8'h0A, 8'h00}, {1'h1, 8'h41, 8'h00}, {1'h1, 8'h42, 8'h00}};

    logic                             clk_i;
    logic                             srst_i;
    exposure_timing_pkg::reg_req_t    reg_req_i;
    logic [7:0]                       reg_rdata_o;
    logic                             binning_mode_i;
    logic                             ext_clk_i;
    exposure_timing_pkg::sync_out_t   sync_o;
    exposure_timing_pkg::timing_set_t active_o;
    int                               err_count;
    int                               checks_done;
    int                               ext_half;
    int                               ext_cnt;
    int                               n;
    logic [15:0]                      v;

    exposure_frame_timing #(.ACTIVE_ROWS(ROWS), .ACTIVE_WIDTH(WIDTH)) i_exposure_frame_timing (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .reg_req_i      (reg_req_i),
        .reg_rdata_o    (reg_rdata_o),
        .binning_mode_i (binning_mode_i),
        .ext_clk_i      (ext_clk_i),
        .sync_o         (sync_o),
        .active_o       (active_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // External row source toggles every ext_half cycles when enabled
    always @(negedge clk_i)
    begin
        ext_cnt = ext_cnt + 1;
        if (ext_half > 0 && ext_cnt >= ext_half)
        begin
            ext_cnt = 0;
            ext_clk_i = ~ext_clk_i;
        end
    end

    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_req_i = '{page: pg, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk_i);
        reg_req_i = '0;
    endtask

    // Read data is registered, so it is taken one cycle after the strobe
    task automatic rd(input logic pg, input logic [7:0] a, output logic [7:0] q);
        @(negedge clk_i);
        reg_req_i = '{page: pg, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk_i);
        reg_req_i = '0;
        q = reg_rdata_o;
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] q);
        rd(1'b1, a, q[15:8]);
        rd(1'b1, a + 8'h01, q[7:0]);
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return sync_o.timer_tick;
            1: return sync_o.row_tick;
            2: return sync_o.data_tick;
            default: return sync_o.frame_start;
        endcase
    endfunction

    // Cycles until the selected pulse is seen, capped so a hang ends
    task automatic wait_pulse(input int sel, output int cyc);
        cyc = 0;
        do
        begin
            @(negedge clk_i);
            cyc++;
        end while (pick(sel) !== 1'b1 && cyc < 20000);
    endtask

    task automatic frames(input int k);
        repeat (k) wait_pulse(3, n);
    endtask

    // Third interval, after the divider change has settled
    task automatic period(input int sel, input int exp, input string what);
        repeat (3) wait_pulse(sel, n);
        check(16'(n), 16'(exp), what);
    endtask

    initial
    begin
        #(20 * 90000);
        err_count++;
        $display("BAD t=%0t watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        logic [7:0] q;
        srst_i = 1'b1;
        reg_req_i = '0;
        binning_mode_i = 1'b0;
        ext_clk_i = 1'b0;
        ext_half = 0;
        ext_cnt = 0;
        err_count = 0;
        checks_done = 0;
        repeat (16) @(negedge clk_i);
        srst_i = 1'b0;

        for (int i = 0; i < 12; i++)
        begin
            rd(RST_TAB[i][16], RST_TAB[i][15:8], q);
            check(16'(q), 16'(RST_TAB[i][7:0]), "reset value");
        end
        check(active_o.exposure, 16'h019A, "active exposure");
        wr(1'b1, 8'hDA, 8'h55);
        rd16(8'hDA, v);
        check(v, WIDTH, "line total read only");
        rd(1'b1, 8'h02, q);
        check(16'(q), 16'h0000, "unmapped read");
        $display("test reset and map done");

        for (int p = 0; p < 2; p++)
            for (int t = 0; t < 4; t++)
            begin
                wr(1'b0, 8'h31, {p[0], 4'h0, (t == 3) ? 3'h4 : t[2:0]});
                period(0, (p + 1) << t, "timer period");
            end
        for (int r = 0; r < 4; r++)
        begin
            wr(1'b0, 8'h31, {1'b0, (r == 3) ? 3'h4 : r[2:0], 4'h0});
            period(1, 1 << r, "row period");
        end
        for (int d = 0; d < 3; d++)
        begin
            wr(1'b0, 8'h31, 8'h01);
            wr(1'b0, 8'h32, {6'h00, d[1:0]});
            period(2, 2 << d, "data period");
        end
        ext_half = 3;
        wr(1'b0, 8'h31, 8'h10);
        wr(1'b0, 8'h32, 8'h10);
        period(1, 12, "external row period");
        ext_half = 0;
        wr(1'b0, 8'h32, 8'h00);
        wr(1'b0, 8'h31, 8'h00);
        $display("test dividers done");

        // Hold disabled: buffered values follow at each frame end
        wr(1'b1, 8'h09, 8'h01);
        wr(1'b1, 8'h0A, 8'h23);
        frames(2);
        check(16'(active_o.hblank), 16'h0123, "hblank commit");
        rd16(8'hDA, v);
        check(v, WIDTH + 16'h0123, "line total");
        wr(1'b1, 8'h09, 8'h00);
        wr(1'b1, 8'h0A, 8'h00);
        wr(1'b1, 8'h01, 8'h01);
        frames(2);
        rd(1'b1, 8'h01, q);
        check(16'(q), 16'h0001, "hold enable");
        $display("test hblank done");

        wr(1'b1, 8'h03, 8'h00);
        wr(1'b1, 8'h04, 8'h00);
        wr(1'b1, 8'h06, 8'h02);
        frames(2);
        check(active_o.vblank, 16'h0000, "held vblank");
        wr(1'b1, 8'h01, 8'h01);
        frames(3);
        check(active_o.vblank, 16'h0002, "vblank commit");
        check(active_o.exposure, 16'h0001, "exposure floor");
        rd16(8'h4E, v);
        check(v, ROWS + 16'h0003, "frame length");
        binning_mode_i = 1'b1;
        frames(2);
        rd16(8'h4E, v);
        check(v, (ROWS + 16'h0003) >> 1, "binned frame length");
        binning_mode_i = 1'b0;
        $display("test group hold done");

        wr(1'b1, 8'h03, 8'h01);
        wr(1'b1, 8'h04, 8'h00);
        wr(1'b1, 8'h42, 8'h05);
        wr(1'b1, 8'h01, 8'h01);
        frames(3);
        check(active_o.long_delay, 16'h0005, "long delay commit");
        rd16(8'h4E, v);
        check(v, ROWS + 16'h0008, "long frame length");
        $display("test long exposure done");

        wr(1'b1, 8'h08, 8'h03);
        frames(1);
        n = 0;
        while (sync_o.vsync !== 1'b1 && n < 5000)
        begin
            @(negedge clk_i);
            n++;
        end
        check(16'(sync_o.vsync), 16'h0001, "frame sync");
        n = 0;
        while (sync_o.line_valid !== 1'b1 && n < 5000)
        begin
            @(negedge clk_i);
            n++;
        end
        check(16'(n), 16'h0003 * WIDTH, "sync to first line");
        check(16'(sync_o.hsync), 16'h0001, "first line sync");
        $display("test sync offset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
